// ### src/spc_pkg.sv
package spc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STAT   = 8'h04;
    localparam logic [7:0]  ADDR_MASK   = 8'h08;
    localparam logic [7:0]  ADDR_SADDR  = 8'h0C;
    localparam logic [7:0]  ADDR_DATA   = 8'h10;

    // ----------------------------------------------------------------
    // serial_port_control fields
    // ----------------------------------------------------------------
    localparam int BIT_PORT_ENABLE  = 15;
    localparam int BIT_IDLE_STOP    = 13;
    localparam int BIT_CLK_RELEASE  = 12;
    localparam int BIT_MGMT_ACK_ALL = 11;
    localparam int BIT_TEN_BIT      = 10;
    localparam int BIT_SLEW_DIS     = 9;
    localparam int BIT_SMBUS_LEVEL  = 8;
    localparam int BIT_GCALL_EN     = 7;
    localparam int BIT_STRETCH_EN   = 6;
    localparam int BIT_ACK_VALUE    = 5;
    localparam int BIT_REQ_LSB      = 0;
    localparam int REQ_BITS         = 5;
    localparam logic [15:0] CTRL_RESET = 16'h1000;
    localparam logic [15:0] CTRL_WMASK = 16'hBFFF;

    // ----------------------------------------------------------------
    // status / mask bits
    // ----------------------------------------------------------------
    localparam int STAT_BITS       = 4;
    localparam int STAT_ADDR_MATCH = 0;
    localparam int STAT_GCALL      = 1;
    localparam int STAT_RX_BYTE    = 2;
    localparam int STAT_SEQ_DONE   = 3;
    localparam logic [STAT_BITS-1:0] STAT_RESET = 4'h0;
    localparam logic [9:0]  SADDR_RESET = 10'h000;
    localparam logic [7:0]  TEN_BIT_PREFIX = 8'hF0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SEQ_TIME_NS   = 5000;
    localparam int SEQ_CYCLES    = (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SEQ_LAST = 8'(SEQ_CYCLES - 1);

    // ----------------------------------------------------------------
    // slave engine states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ADDR  = 5'b00010,
        ST_ADDR2 = 5'b00100,
        ST_RX    = 5'b01000,
        ST_TX    = 5'b10000
    } spc_state_type;

endpackage : spc_pkg

// ### src/spc_slave.sv
`timescale 1ns/1ps
`default_nettype none
module spc_slave (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ten_bit,
    input  wire logic       ack_all,
    input  wire logic       gc_en,
    input  wire logic [9:0] own_addr,
    input  wire logic [7:0] tx_byte,
    output var  logic       sda_drive,
    output var  logic [7:0] rx_byte,
    output var  logic       addr_end,
    output var  logic       data_end,
    output var  logic       tx_begin,
    output var  logic       gc_hit,
    output logic            active
);

    spc_pkg::spc_state_type state_reg;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic       hit_reg;
    logic       rw_reg;
    logic [7:0] b;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;

    // ----------------------------------------------------------------
    // line events
    // ----------------------------------------------------------------
    assign scl_rise   = scl & ~scl_q;
    assign scl_fall   = ~scl & scl_q;
    assign start_cond = scl & scl_q & sda_q & ~sda;
    assign stop_cond  = scl & scl_q & ~sda_q & sda;
    assign b          = {shift_reg[6:0], sda};
    assign active     = (state_reg != spc_pkg::ST_IDLE) & hit_reg & ((bit_cnt_reg == 4'h0) | addr_end);

    // previous line levels for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // ----------------------------------------------------------------
    // byte engine: address compare, ack slot, receive and transmit
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= spc_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            hit_reg     <= 1'b0;
            rw_reg      <= 1'b0;
            sda_drive   <= 1'b0;
            rx_byte     <= 8'h00;
            addr_end    <= 1'b0;
            data_end    <= 1'b0;
            tx_begin    <= 1'b0;
            gc_hit      <= 1'b0;
        end else begin
            addr_end <= 1'b0;
            data_end <= 1'b0;
            tx_begin <= 1'b0;
            gc_hit   <= 1'b0;
            if (!enable || stop_cond) begin
                state_reg <= spc_pkg::ST_IDLE;
                sda_drive <= 1'b0;
                hit_reg   <= 1'b0;
            end else if (start_cond) begin
                state_reg   <= spc_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_drive   <= 1'b0;
            end else if (scl_rise && state_reg != spc_pkg::ST_IDLE && bit_cnt_reg < 4'h8) begin
                shift_reg   <= b;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == 4'h7) begin
                    case (state_reg)
                        spc_pkg::ST_ADDR: begin
                            rw_reg   <= b[0];
                            addr_end <= 1'b1;
                            if (ten_bit) begin
                                hit_reg <= ack_all | ({b[7:3], 3'b000} == spc_pkg::TEN_BIT_PREFIX
                                           && b[2:1] == own_addr[9:8]);
                            end else begin
                                hit_reg <= ack_all | (b[7:1] == own_addr[6:0])
                                           | (gc_en & (b == 8'h00));
                            end
                            gc_hit <= gc_en & (b == 8'h00);
                        end
                        spc_pkg::ST_ADDR2: begin
                            addr_end <= 1'b1;
                            hit_reg  <= hit_reg & (ack_all | (b == own_addr[7:0]));
                        end
                        spc_pkg::ST_RX: begin
                            rx_byte  <= b;
                            data_end <= 1'b1;
                        end
                        spc_pkg::ST_TX: begin
                        end
                        default: state_reg <= spc_pkg::ST_IDLE;
                    endcase
                end
            end else if (scl_rise && state_reg == spc_pkg::ST_TX && bit_cnt_reg == 4'h9) begin
                // master answered the byte: a nack ends the read
                if (sda) begin
                    state_reg <= spc_pkg::ST_IDLE;
                end
            end else if (scl_fall && state_reg != spc_pkg::ST_IDLE) begin
                if (bit_cnt_reg == 4'h8) begin
                    bit_cnt_reg <= 4'h9;
                    sda_drive   <= (state_reg != spc_pkg::ST_TX) & hit_reg;
                    if (!hit_reg) begin
                        state_reg <= spc_pkg::ST_IDLE;
                    end
                end else if (bit_cnt_reg == 4'h9) begin
                    bit_cnt_reg <= 4'h0;
                    sda_drive   <= 1'b0;
                    if ((state_reg == spc_pkg::ST_ADDR && rw_reg) || state_reg == spc_pkg::ST_TX) begin
                        state_reg <= spc_pkg::ST_TX;
                        shift_reg <= tx_byte;
                        sda_drive <= ~tx_byte[7];
                        tx_begin  <= 1'b1;
                    end else if (state_reg == spc_pkg::ST_ADDR && ten_bit) begin
                        state_reg <= spc_pkg::ST_ADDR2;
                    end else begin
                        state_reg <= spc_pkg::ST_RX;
                    end
                end else if (state_reg == spc_pkg::ST_TX) begin
                    sda_drive <= ~shift_reg[7];
                end
            end
        end
    end

endmodule : spc_slave
`default_nettype wire

// ### src/spc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // ----------------------------------------------------------------
    // two-flop synchroniser, one chain per bit
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // bus lines idle high, so reset to the idle level
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[i] <= 1'b1;
                    q[i]        <= 1'b1;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i]        <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule : spc_sync
`default_nettype wire

// ### src/spc_top.sv
// Summary of operation
// - clearing port enable stops the port and hands both pins back to port logic
// - as slave, clock release one lets clock go, zero holds clock low
// - with stretching on, software writes zero to stretch, one to release
// - stretching on: release cleared at transmit byte start and receive data byte end
// - stretching off: zero writes ignored; cleared at transmit start and address end
// - management mode acknowledges every address regardless of own address
// - hardware clears clock release and the five master request bits
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        irq,
    input  wire logic        scl_in,
    output var  logic        scl_out,
    output var  logic        scl_oe,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe,
    output var  logic        port_owns_pins,
    output var  logic        slew_ctl_active,
    output var  logic        smbus_levels,
    output var  logic        idle_stop
);

    logic [15:0]                  ctrl_reg;
    logic [15:0]                  ctrl_next;
    logic [spc_pkg::STAT_BITS-1:0] stat_reg;
    logic [spc_pkg::STAT_BITS-1:0] mask_reg;
    logic [spc_pkg::STAT_BITS-1:0] events;
    logic [9:0]                   saddr_reg;
    logic [7:0]                   tx_reg;
    logic [7:0]                   seq_cnt_reg;
    logic [spc_pkg::REQ_BITS-1:0] req;
    logic [spc_pkg::REQ_BITS-1:0] req_clr;
    logic                         seq_done;
    logic [1:0]                   line_s;
    logic                         wr_en;
    logic                         sel_ok;
    logic [31:0]                  rd_mux;
    logic                         port_en;
    logic                         stretch_en;
    logic                         rel_clr;
    logic                         eng_drive;
    logic [7:0]                   eng_rx;
    logic                         eng_addr_end;
    logic                         eng_data_end;
    logic                         eng_tx_begin;
    logic                         eng_gc_hit;
    logic                         eng_active;

    assign port_en    = ctrl_reg[spc_pkg::BIT_PORT_ENABLE];
    assign stretch_en = ctrl_reg[spc_pkg::BIT_STRETCH_EN];
    assign req        = ctrl_reg[spc_pkg::BIT_REQ_LSB +: spc_pkg::REQ_BITS];

    // ----------------------------------------------------------------
    // pin synchronisers and slave engine
    // ----------------------------------------------------------------
    spc_sync #(
        .W (2)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({scl_in, sda_in}),
        .q     (line_s)
    );

    spc_slave u_slave (
        .clk       (pclk),
        .rst_n     (presetn),
        .enable    (port_en),
        .scl       (line_s[1]),
        .sda       (line_s[0]),
        .ten_bit   (ctrl_reg[spc_pkg::BIT_TEN_BIT]),
        .ack_all   (ctrl_reg[spc_pkg::BIT_MGMT_ACK_ALL]),
        .gc_en     (ctrl_reg[spc_pkg::BIT_GCALL_EN]),
        .own_addr  (saddr_reg),
        .tx_byte   (tx_reg),
        .sda_drive (eng_drive),
        .rx_byte   (eng_rx),
        .addr_end  (eng_addr_end),
        .data_end  (eng_data_end),
        .tx_begin  (eng_tx_begin),
        .gc_hit    (eng_gc_hit),
        .active    (eng_active)
    );

    // ----------------------------------------------------------------
    // apb slave: zero wait, answer in first access cycle
    // ----------------------------------------------------------------
    assign wr_en  = psel & penable & pready & pwrite & ~pslverr;
    assign sel_ok = (paddr == spc_pkg::ADDR_CTRL) | (paddr == spc_pkg::ADDR_STAT)
                  | (paddr == spc_pkg::ADDR_MASK) | (paddr == spc_pkg::ADDR_SADDR)
                  | (paddr == spc_pkg::ADDR_DATA);

    // read data; reserved bits and unmapped words read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            spc_pkg::ADDR_CTRL:  rd_mux = {16'h0000, ctrl_reg};
            spc_pkg::ADDR_STAT:  rd_mux = {28'h000_0000, stat_reg};
            spc_pkg::ADDR_MASK:  rd_mux = {28'h000_0000, mask_reg};
            spc_pkg::ADDR_SADDR: rd_mux = {22'h00_0000, saddr_reg};
            spc_pkg::ADDR_DATA:  rd_mux = {24'h00_0000, eng_rx};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // answer flops are loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~sel_ok;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // control register with hardware-cleared bits
    // ----------------------------------------------------------------
    // stretch-off mode clears release at address end, stretch-on at data end
    assign rel_clr = port_en & (eng_tx_begin
                   | (stretch_en ? eng_data_end : eng_addr_end));

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_en && paddr == spc_pkg::ADDR_CTRL) begin
            ctrl_next = pwdata[15:0] & spc_pkg::CTRL_WMASK;
            // without stretching, only a one can be written here
            if (!stretch_en && !pwdata[spc_pkg::BIT_CLK_RELEASE]) begin
                ctrl_next[spc_pkg::BIT_CLK_RELEASE] = ctrl_reg[spc_pkg::BIT_CLK_RELEASE];
            end
        end
        // hardware clears win so a byte boundary is never missed
        if (rel_clr) begin
            ctrl_next[spc_pkg::BIT_CLK_RELEASE] = 1'b0;
        end
        ctrl_next[spc_pkg::BIT_REQ_LSB +: spc_pkg::REQ_BITS] =
            ctrl_next[spc_pkg::BIT_REQ_LSB +: spc_pkg::REQ_BITS] & ~req_clr;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= spc_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // own address and transmit byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            saddr_reg <= spc_pkg::SADDR_RESET;
            tx_reg    <= 8'h00;
        end else begin
            if (wr_en && paddr == spc_pkg::ADDR_SADDR) begin
                saddr_reg <= pwdata[9:0];
            end
            if (wr_en && paddr == spc_pkg::ADDR_DATA) begin
                tx_reg <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // master request sequencer: one request served at a time
    // ----------------------------------------------------------------
    // lowest set bit first, so start precedes the others
    always_comb begin
        req_clr = '0;
        if (seq_done) begin
            req_clr = req & (~req + 5'h01);
        end
    end

    assign seq_done = port_en & (|req) & (seq_cnt_reg == spc_pkg::SEQ_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_cnt_reg <= 8'h00;
        end else if (!port_en || !(|req) || seq_done) begin
            seq_cnt_reg <= 8'h00;
        end else begin
            seq_cnt_reg <= seq_cnt_reg + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // sticky status, mask and interrupt
    // ----------------------------------------------------------------
    assign events = {seq_done, eng_data_end, eng_gc_hit, eng_addr_end & eng_active};

    // set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= spc_pkg::STAT_RESET;
            mask_reg <= spc_pkg::STAT_RESET;
        end else begin
            if (wr_en && paddr == spc_pkg::ADDR_STAT) begin
                stat_reg <= (stat_reg & ~pwdata[spc_pkg::STAT_BITS-1:0]) | events;
            end else begin
                stat_reg <= stat_reg | events;
            end
            if (wr_en && paddr == spc_pkg::ADDR_MASK) begin
                mask_reg <= pwdata[spc_pkg::STAT_BITS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // registered pin and mode outputs
    // ----------------------------------------------------------------
    // open drain: out stays low, enable pulls the line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq             <= 1'b0;
            scl_out         <= 1'b0;
            sda_out         <= 1'b0;
            scl_oe          <= 1'b0;
            sda_oe          <= 1'b0;
            port_owns_pins  <= 1'b1;
            slew_ctl_active <= 1'b1;
            smbus_levels    <= 1'b0;
            idle_stop       <= 1'b0;
        end else begin
            irq             <= |(stat_reg & mask_reg);
            scl_out         <= 1'b0;
            sda_out         <= 1'b0;
            scl_oe          <= port_en & eng_active & ~ctrl_reg[spc_pkg::BIT_CLK_RELEASE];
            sda_oe          <= port_en & eng_drive;
            port_owns_pins  <= ~port_en;
            slew_ctl_active <= ~ctrl_reg[spc_pkg::BIT_SLEW_DIS];
            smbus_levels    <= ctrl_reg[spc_pkg::BIT_SMBUS_LEVEL];
            idle_stop       <= ctrl_reg[spc_pkg::BIT_IDLE_STOP];
        end
    end

endmodule : spc_top
`default_nettype wire

// ### test/spc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module spc_bus_master (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output var  logic scl_in,
    output var  logic sda_in
);
    logic m_scl = 1'b1, m_sda = 1'b1;
    // wired-and with pull-ups: a released line reads high
    always_comb scl_in = m_scl & ~scl_oe;
    always_comb sda_in = m_sda & ~sda_oe;
    // one bit, 320 ns; the slave may stretch the low phase
    task automatic bit_x(input logic d, output logic r);
        m_sda = d;
        #160 m_scl = 1'b1;
        wait (scl_in);
        #80 r = sda_in;
        #80 m_scl = 1'b0;
    endtask : bit_x
    task automatic start_cond();
        m_sda = 1'b0;
        #160 m_scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        m_sda = 1'b0;
        #160 m_scl = 1'b1;
        wait (scl_in);
        #160 m_sda = 1'b1;
        #160;
    endtask : stop_cond
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask : rd_byte
endmodule : spc_bus_master
`default_nettype wire

// ### test/spc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module spc_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_oe,
    input wire logic        sda_oe,
    input wire logic        port_owns_pins,
    input wire logic        slew_ctl_active,
    input wire logic        smbus_levels,
    input wire logic        idle_stop
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a control read shows the register, so pin state is judged against it
    wire ctrl_rd = pready && !pwrite && paddr == spc_pkg::ADDR_CTRL;
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_unmapped_err: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_pins_returned: assert property (port_owns_pins |-> !scl_oe && !sda_oe) else $error("pins driven");
    a_enable_mirror: assert property (ctrl_rd |-> port_owns_pins == !prdata[15]) else $error("pin owner");
    a_slew_mirror: assert property (ctrl_rd |-> slew_ctl_active == !prdata[9]) else $error("slew state");
    a_release_held: assert property (ctrl_rd && prdata[12] |-> !scl_oe) else $error("clock still held");
    a_levels_mirror: assert property (ctrl_rd |-> smbus_levels == prdata[8] && idle_stop == prdata[13])
        else $error("level or idle select wrong");
endmodule : spc_sva
bind spc_top spc_sva u_sva (.*);
`default_nettype wire

// ### test/spc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spc_top_tb;
    localparam logic [7:0] AC = spc_pkg::ADDR_CTRL;
    localparam logic [7:0] AS = spc_pkg::ADDR_STAT;
    localparam logic [7:0] AM = spc_pkg::ADDR_MASK;
    localparam logic [7:0] AO = spc_pkg::ADDR_SADDR;
    localparam logic [7:0] AD = spc_pkg::ADDR_DATA;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic [7:0]  b;
    logic        pready, pslverr, irq, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, ack, err;
    logic        port_owns_pins, slew_ctl_active, smbus_levels, idle_stop;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [15:0] tctl [4] = '{16'h9000, 16'h9800, 16'h9080, 16'h9400};
    logic [9:0]  town [4] = '{10'h02A, 10'h02A, 10'h02A, 10'h2A5};
    logic [7:0]  tadr [4] = '{8'h56, 8'h56, 8'h00, 8'hF4};
    logic        tack [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    spc_top dut (.*);
    spc_bus_master mdl (.*);
    // 25 MHz system clock
    always #20 pclk = ~pclk;
    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one transfer; data taken and request released at the edge that samples ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc
    // settle past the edge so registered outputs are stable
    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : hold
    task automatic final_report();
        $display("miscompares=%0d n_compared=%0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // a stuck link or bus ends the run well past the expected span
    initial begin
        #2_000_000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(AC, 32'h0000_1000);
        rdc(AS, 32'h0000_0000);
        chk(port_owns_pins, 1'b1);
        chk(slew_ctl_active, 1'b1);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({err, rd}, 33'h1_0000_0000);
        apb(1'b1, AC, 32'h0000_E300);
        rdc(AC, 32'h0000_B300);
        chk({scl_out, sda_out, port_owns_pins, slew_ctl_active, smbus_levels, idle_stop}, 6'h03);
        apb(1'b1, AC, 32'h0000_0000);
        hold(2);
        chk(port_owns_pins, 1'b1);
        // stretch off: receive one byte, then interrupt handling
        apb(1'b1, AO, 32'h0000_002A);
        apb(1'b1, AM, 32'h0000_000F);
        apb(1'b1, AC, 32'h0000_9000);
        mdl.start_cond();
        mdl.wr_byte(8'h54, ack);
        chk(ack, 1'b1);
        hold(20);
        chk(scl_oe, 1'b1);
        rdc(AC, 32'h0000_8000);
        apb(1'b1, AC, 32'h0000_9000);
        hold(2);
        chk(scl_oe, 1'b0);
        mdl.wr_byte(8'h5A, ack);
        hold(20);
        chk(scl_oe, 1'b0);
        mdl.stop_cond();
        rdc(AD, 32'h0000_005A);
        rdc(AS, 32'h0000_0005);
        chk(irq, 1'b1);
        apb(1'b1, AM, 32'h0000_0000);
        hold(2);
        chk(irq, 1'b0);
        apb(1'b1, AM, 32'h0000_000F);
        hold(2);
        chk(irq, 1'b1);
        apb(1'b1, AS, 32'h0000_0005);
        hold(2);
        chk(irq, 1'b0);
        // stretch on: transmit, then receive with a software stretch
        apb(1'b1, AC, 32'h0000_9040);
        apb(1'b1, AD, 32'h0000_00C3);
        mdl.start_cond();
        mdl.wr_byte(8'h55, ack);
        hold(20);
        chk(scl_oe, 1'b1);
        apb(1'b1, AC, 32'h0000_9040);
        mdl.rd_byte(1'b1, b);
        chk(b, 8'hC3);
        mdl.stop_cond();
        apb(1'b1, AC, 32'h0000_9040);
        mdl.start_cond();
        mdl.wr_byte(8'h54, ack);
        hold(20);
        chk(scl_oe, 1'b0);
        apb(1'b1, AC, 32'h0000_8040);
        hold(2);
        chk(scl_oe, 1'b1);
        apb(1'b1, AC, 32'h0000_9040);
        hold(2);
        chk(scl_oe, 1'b0);
        mdl.wr_byte(8'h11, ack);
        hold(20);
        chk(scl_oe, 1'b1);
        rdc(AC, 32'h0000_8040);
        apb(1'b1, AC, 32'h0000_9040);
        mdl.stop_cond();
        // address modes: miss, acknowledge-all, general call, ten-bit
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, AO, {22'h0, town[i]});
            apb(1'b1, AC, {16'h0, tctl[i]});
            mdl.start_cond();
            mdl.wr_byte(tadr[i], ack);
            chk(ack, tack[i]);
            apb(1'b1, AC, {16'h0, tctl[i]});
            if (i == 3) begin
                mdl.wr_byte(8'hA5, ack);
                chk(ack, 1'b1);
                apb(1'b1, AC, {16'h0, tctl[i]});
            end
            mdl.stop_cond();
        end
        apb(1'b0, AS, 32'h0000_0000);
        chk(rd[1], 1'b1);
        // master requests with acknowledge-all kept clear
        apb(1'b1, AC, 32'h0000_901F);
        hold(128);
        rdc(AC, 32'h0000_901E);
        hold(700);
        rdc(AC, 32'h0000_9000);
        apb(1'b0, AS, 32'h0000_0000);
        chk(rd[3], 1'b1);
        final_report();
    end
endmodule : spc_top_tb
`default_nettype wire
